// *** core/sac_adc_control.sv ***
// control and status logic of the 8-bit successive-approximation converter
//
// Local design decisions: register access over AHB-Lite and the register offsets.
`timescale 1ns/100ps

module sac_adc_control (
   // clock and reset
   input wire logic CLK_I,
   input wire logic RESET_N_I,
   // ahb-lite slave
   input wire logic HSEL_I,
   input wire logic [sac_pkg::ADDR_W-1:0] HADDR_I,
   input wire logic [1:0] HTRANS_I,
   input wire logic HWRITE_I,
   input wire logic [2:0] HSIZE_I,
   input wire logic [31:0] HWDATA_I,
   input wire logic HREADY_I,
   output logic [31:0] HRDATA_O,
   output logic HREADYOUT_O,
   output logic [1:0] HRESP_O,
   // analog front end
   input wire logic COMP_I,
   output logic [7:0] TRIAL_O,
   output logic SAMPLE_O,
   output logic [2:0] CHAN_O,
   output logic CHAN_EN_O,
   // trigger pin and interrupt request
   input wire logic EXT_TRIGGER_PIN_I,
   output logic IRQ_O
);
   import sac_pkg::*;

   // ****************************************
   // declarations
   // ****************************************
   sac_state_t state;
   sac_state_t next_state;
   logic [CNT_W-1:0] cnt;
   logic [CNT_W-1:0] next_cnt;
   logic [CNT_W-1:0] period_q;
   logic [7:0] trial;
   logic [7:0] next_trial;
   logic [7:0] bit_mask;
   logic [7:0] next_mask;
   logic [7:0] conversion_result;
   logic speed_select;
   logic ext_trigger_enable;
   logic [3:0] input_select;
   logic conv_done_request;
   logic conv_done_irq_enable;
   logic trigger_edge_polarity;
   logic wr_pend;
   logic rd_pend;
   logic [OFF_W-1:0] addr_q;
   logic addr_ok_q;
   logic trig_s1;
   logic trig_s2;
   logic trig_d;

   // ****************************************
   // bus decode
   // ****************************************
   wire ahb_take = HSEL_I & HTRANS_I[TRANS_ACT] & HREADY_I;
   wire addr_ok = (HADDR_I[ADDR_W-1:OFF_W] == '0) &&
                  (HADDR_I[1:0] == 2'h0);
   wire wr_hit = wr_pend & addr_ok_q;
   wire wr_mode = wr_hit & (addr_q == OFF_MODE);
   wire wr_go = wr_hit & (addr_q == OFF_GO);
   wire wr_irq = wr_hit & (addr_q == OFF_IRQ);
   wire sel_mode = addr_ok_q & (addr_q == OFF_MODE);
   wire sel_result = addr_ok_q & (addr_q == OFF_RESULT);
   wire sel_go = addr_ok_q & (addr_q == OFF_GO);
   wire sel_irq = addr_ok_q & (addr_q == OFF_IRQ);

   // ****************************************
   // start, abort and trigger
   // ****************************************
   wire active = (state != ST_IDLE);
   wire sw_start = wr_go & HWDATA_I[GO_FLAG];
   wire sw_abort = wr_go & ~HWDATA_I[GO_FLAG];
   wire trig_rise = trig_s2 & ~trig_d;
   wire trig_fall = ~trig_s2 & trig_d;
   wire trig_hit = trigger_edge_polarity ? trig_rise : trig_fall;
   wire trig_start = trig_hit & ext_trigger_enable & ~active & ~wr_go;
   wire start_any = sw_start | trig_start;
   wire [CNT_W-1:0] start_period =
      speed_select ? PERIOD_FAST : PERIOD_SLOW;
   wire [CNT_W-1:0] sample_end = period_q - SAR_STEPS - 6'h01;

   // ****************************************
   // successive approximation step
   // ****************************************
   // keep bit when input is at or above trial
   wire [7:0] decided = COMP_I ? trial : (trial & ~bit_mask);
   wire finish = (state == ST_RESOLVE) & bit_mask[0];
   // a write to the go register in the same cycle wins over completion
   wire finish_ok = finish & ~wr_go;

   // ****************************************
   // read mux
   // ****************************************
   wire [7:0] mode_rd = {speed_select, ext_trigger_enable,
                         MODE_RSVD, input_select};
   wire [7:0] go_rd = {active, GO_RSVD};
   wire [2:0] irq_rd = {trigger_edge_polarity, conv_done_irq_enable,
                        conv_done_request};
   wire [31:0] rd_word =
      sel_mode ? {24'h000000, mode_rd} :
      sel_result ? {24'h000000, conversion_result} :
      sel_go ? {24'h000000, go_rd} :
      sel_irq ? {29'h00000000, irq_rd} : 32'h00000000;

   // channel decode: 01xx and 10xx are real inputs
   wire chan_valid = input_select[3] ^ input_select[2];
   wire [2:0] chan_idx = {input_select[3], input_select[1:0]};

   // ****************************************
   // next-state logic
   // ****************************************
   always_comb begin
      next_state = state;
      next_cnt = cnt;
      next_trial = trial;
      next_mask = bit_mask;
      if (sw_abort) begin
         next_state = ST_IDLE;
      end else if (start_any) begin
         next_state = ST_SAMPLE;
         next_cnt = '0;
         next_trial = SAR_MSB;
         next_mask = SAR_MSB;
      end else begin
         unique case (state)
            ST_IDLE: begin
               next_state = ST_IDLE;
            end
            ST_SAMPLE: begin
               next_cnt = cnt + 6'h01;
               if (cnt == sample_end) begin
                  next_state = ST_RESOLVE;
               end
            end
            ST_RESOLVE: begin
               next_cnt = cnt + 6'h01;
               next_trial = decided | (bit_mask >> 1);
               next_mask = bit_mask >> 1;
               if (finish) begin
                  next_state = ST_IDLE;
               end
            end
         endcase
      end
   end

   // ****************************************
   // bus slave
   // ****************************************
   always_ff @(posedge CLK_I) begin
      if (!RESET_N_I) begin
         wr_pend <= 1'b0;
         rd_pend <= 1'b0;
         addr_q <= '0;
         addr_ok_q <= 1'b0;
      end else begin
         wr_pend <= ahb_take & HWRITE_I;
         rd_pend <= ahb_take & ~HWRITE_I;
         if (ahb_take) begin
            addr_q <= HADDR_I[OFF_W-1:0];
            addr_ok_q <= addr_ok;
         end
      end
   end

   // reads take one wait state so a write just before is visible
   always_ff @(posedge CLK_I) begin
      if (!RESET_N_I) begin
         HREADYOUT_O <= 1'b1;
         HRDATA_O <= 32'h00000000;
         HRESP_O <= RESP_OKAY;
      end else begin
         HREADYOUT_O <= ~(ahb_take & ~HWRITE_I);
         HRESP_O <= RESP_OKAY;
         if (rd_pend) begin
            HRDATA_O <= rd_word;
         end
      end
   end

   // ****************************************
   // mode and interrupt control registers
   // ****************************************
   always_ff @(posedge CLK_I) begin
      if (!RESET_N_I) begin
         speed_select <= MODE_RESET[MODE_SPEED];
         ext_trigger_enable <= MODE_RESET[MODE_TRIG];
         input_select <= MODE_RESET[3:0];
         conv_done_irq_enable <= 1'b0;
         trigger_edge_polarity <= 1'b0;
      end else begin
         if (wr_mode) begin
            speed_select <= HWDATA_I[MODE_SPEED];
            ext_trigger_enable <= HWDATA_I[MODE_TRIG];
            input_select <= HWDATA_I[3:0];
         end
         if (wr_irq) begin
            conv_done_irq_enable <= HWDATA_I[IRQ_EN];
            trigger_edge_polarity <= HWDATA_I[IRQ_POL];
         end
      end
   end

   // done flag, set wins over clear
   always_ff @(posedge CLK_I) begin
      if (!RESET_N_I) begin
         conv_done_request <= 1'b0;
      end else if (finish_ok) begin
         conv_done_request <= 1'b1;
      end else if (wr_irq & HWDATA_I[IRQ_REQ]) begin
         conv_done_request <= 1'b0;
      end
   end

   always_ff @(posedge CLK_I) begin
      if (!RESET_N_I) begin
         IRQ_O <= 1'b0;
      end else begin
         IRQ_O <= conv_done_request & conv_done_irq_enable;
      end
   end

   // ****************************************
   // trigger synchroniser
   // ****************************************
   // two-stage sync then edge
   always_ff @(posedge CLK_I) begin
      if (!RESET_N_I) begin
         trig_s1 <= 1'b1;
         trig_s2 <= 1'b1;
         trig_d <= 1'b1;
      end else begin
         trig_s1 <= EXT_TRIGGER_PIN_I;
         trig_s2 <= trig_s1;
         trig_d <= trig_s2;
      end
   end

   // ****************************************
   // conversion sequencer
   // ****************************************
   always_ff @(posedge CLK_I) begin
      if (!RESET_N_I) begin
         state <= ST_IDLE;
         cnt <= '0;
         trial <= 8'h00;
         bit_mask <= 8'h00;
         period_q <= PERIOD_SLOW;
      end else begin
         state <= next_state;
         cnt <= next_cnt;
         trial <= next_trial;
         bit_mask <= next_mask;
         if (start_any) begin
            period_q <= start_period;
         end
      end
   end

   always_ff @(posedge CLK_I) begin
      if (finish_ok) begin
         conversion_result <= decided;
      end
   end

   // ****************************************
   // front-end outputs
   // ****************************************
   always_ff @(posedge CLK_I) begin
      if (!RESET_N_I) begin
         TRIAL_O <= 8'h00;
         SAMPLE_O <= 1'b0;
         CHAN_O <= 3'h0;
         CHAN_EN_O <= 1'b0;
      end else begin
         TRIAL_O <= next_trial;
         SAMPLE_O <= (next_state == ST_SAMPLE);
         CHAN_O <= chan_idx;
         CHAN_EN_O <= chan_valid;
      end
   end

   // ****************************************
   // checks
   // ****************************************
   default clocking cb @(posedge CLK_I);
   endclocking
   default disable iff (!RESET_N_I);

   logic [CNT_W-1:0] busy_len;
   always_ff @(posedge CLK_I) begin
      if (!RESET_N_I || sw_abort) begin
         busy_len <= '0;
      end else if (start_any) begin
         busy_len <= 6'h01;
      end else if (active) begin
         busy_len <= busy_len + 6'h01;
      end
   end

   a_mode_reset_val:
      assert property (disable iff (1'b0)
         !RESET_N_I |=> mode_rd == MODE_RESET)
      else $error("mode register not 30 hex after reset");

   a_conv_length_ok:
      assert property (finish |-> busy_len == period_q)
      else $error("conversion length differs from period");

   a_slow_speed_sel:
      assert property (start_any && !speed_select
         |=> period_q == PERIOD_SLOW)
      else $error("speed 0 did not select 62 cycles");

   a_result_held:
      assert property (!finish_ok |=> $stable(conversion_result))
      else $error("result changed without completion");

   a_trig_ignored:
      assert property (!ext_trigger_enable && !active && !wr_go
         |=> !active)
      else $error("conversion started with trigger disabled");

   a_trig_starts:
      assert property (trig_hit && ext_trigger_enable && !active
         && !wr_go |=> active ##1 busy_len == 6'h02)
      else $error("enabled trigger edge did not start");

   a_done_sets_req:
      assert property (finish_ok |=> conv_done_request && !active)
      else $error("completion did not set request");

   a_irq_gated:
      assert property (!conv_done_irq_enable |=> !IRQ_O)
      else $error("interrupt raised while disabled");

   a_abort_clears:
      assert property (sw_abort |=> !active && !SAMPLE_O)
      else $error("abort did not stop conversion");

   a_rsvd_read_ones:
      assert property (rd_pend && sel_go
         |=> HRDATA_O[6:0] == GO_RSVD && HREADYOUT_O)
      else $error("go reserved bits not read as ones");

   c_sw_conversion:
      cover property (sw_start ##[1:70] finish_ok);
   c_trig_conversion:
      cover property (trig_start ##[1:70] finish_ok);
   c_abort_midway:
      cover property (active && sw_abort);
   c_irq_raised:
      cover property ($rose(IRQ_O));

endmodule : sac_adc_control

// *** core/sac_pkg.sv ***
// constants, register map and types for the converter control block
package sac_pkg;

   // ****************************************
   // register map (byte offsets, word aligned)
   // ****************************************
   localparam int ADDR_W = 32;
   localparam int OFF_W = 4;
   localparam logic [OFF_W-1:0] OFF_MODE = 4'h0;
   localparam logic [OFF_W-1:0] OFF_RESULT = 4'h4;
   localparam logic [OFF_W-1:0] OFF_GO = 4'h8;
   localparam logic [OFF_W-1:0] OFF_IRQ = 4'hC;

   // ****************************************
   // field positions and reset values
   // ****************************************
   localparam int MODE_SPEED = 7;
   localparam int MODE_TRIG = 6;
   localparam int GO_FLAG = 7;
   localparam int IRQ_REQ = 0;
   localparam int IRQ_EN = 1;
   localparam int IRQ_POL = 2;
   localparam logic [7:0] MODE_RESET = 8'h30;
   localparam logic [1:0] MODE_RSVD = 2'h3;
   localparam logic [6:0] GO_RSVD = 7'h7F;

   // ****************************************
   // conversion timing in system clock cycles
   // ****************************************
   localparam int CNT_W = 6;
   localparam logic [CNT_W-1:0] PERIOD_SLOW = 6'h3E;
   localparam logic [CNT_W-1:0] PERIOD_FAST = 6'h1F;
   localparam logic [CNT_W-1:0] SAR_STEPS = 6'h08;
   localparam logic [7:0] SAR_MSB = 8'h80;

   // ****************************************
   // bus encodings
   // ****************************************
   localparam int TRANS_ACT = 1;
   localparam logic [1:0] RESP_OKAY = 2'h0;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_SAMPLE,
      ST_RESOLVE
   } sac_state_t;

endpackage : sac_pkg

// *** tb/sac_afe_model.sv ***
// behavioural analog front end: sample-and-hold and comparator
`timescale 1ns/100ps

module sac_afe_model (
   // converter side
   input wire logic clk_i,
   input wire logic [7:0] trial_i,
   input wire logic sample_i,
   input wire logic [2:0] chan_i,
   input wire logic chan_en_i,
   // analog level on each input
   input wire logic [7:0] lvl_i [8],
   output logic comp_o
);
   logic [7:0] held;

   initial held = 8'h00;

   // level tracked only while sampling, so a late change is not seen
   always @(posedge clk_i) begin
      if (sample_i === 1'b1) begin
         held <= lvl_i[chan_i];
      end
   end

   assign comp_o = (chan_en_i === 1'b1) && (held >= trial_i);
endmodule : sac_afe_model

// *** tb/sac_adc_control_tb.sv ***
// self-checking bench for the converter control block
`timescale 1ns/100ps

module sac_adc_control_tb;
   import sac_pkg::*;
   logic clk, rst_n, hsel, hwrite, pin, hready, comp, smp_en, irq, chen;
   logic [31:0] haddr, hwdata, hrdata, rv, res;
   logic [1:0] htrans, hresp;
   logic [7:0] trial;
   logic [2:0] chan, hsize;
   logic [7:0] lvl [8];
   int err_total, n_checks, smp;

   sac_adc_control i_dut (.CLK_I(clk), .RESET_N_I(rst_n), .HSEL_I(hsel),
      .HADDR_I(haddr), .HTRANS_I(htrans), .HWRITE_I(hwrite),
      .HSIZE_I(hsize), .HWDATA_I(hwdata), .HREADY_I(hready),
      .HRDATA_O(hrdata), .HREADYOUT_O(hready), .HRESP_O(hresp),
      .COMP_I(comp), .TRIAL_O(trial), .SAMPLE_O(smp_en), .CHAN_O(chan),
      .CHAN_EN_O(chen), .EXT_TRIGGER_PIN_I(pin), .IRQ_O(irq));

   sac_afe_model i_afe (.clk_i(clk), .trial_i(trial), .sample_i(smp_en),
      .chan_i(chan), .chan_en_i(chen), .lvl_i(lvl), .comp_o(comp));

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   always @(posedge clk) begin
      if (smp_en === 1'b1) smp++;
   end

   // ****************************************
   // bus access and comparison
   // ****************************************
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         $display("wrong value %s expected %h seen %h", nm, e, g);
         err_total++;
      end
   endtask : chk

   task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
      @(posedge clk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= a;
      hsize <= 3'h2;
      @(posedge clk);
      while (hready !== 1'b1) @(posedge clk);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= d;
      @(posedge clk);
      while (hready !== 1'b1) @(posedge clk);
      rv = hrdata;
      chk("response", 32'h0, {30'h0, hresp});
   endtask : bus

   task rd_chk(input string nm, input logic [31:0] a, input logic [7:0] e);
      bus(1'b0, a, 32'h0);
      chk(nm, {24'h0, e}, rv);
   endtask : rd_chk

   task wait_done();
      int k;
      k = 0;
      rv = 32'hFF;
      while (rv[7] !== 1'b0 && k < 60) begin
         bus(1'b0, 32'h8, 32'h0);
         k++;
      end
      chk("active flag cleared", 32'h7F, rv);
   endtask : wait_done

   task run_conv(input logic [7:0] md, input logic en, input logic [7:0] e,
                 input int ns);
      bus(1'b1, 32'hC, {30'h0, en, 1'b1});
      bus(1'b1, 32'h0, {24'h0, md});
      rd_chk("mode", 32'h0, md | 8'h30);
      smp = 0;
      bus(1'b1, 32'h8, 32'h80);
      rd_chk("go active", 32'h8, 8'hFF);
      wait_done();
      chk("sample cycles", ns, smp);
      rd_chk("result", 32'h4, e);
      rd_chk("irq reg", 32'hC, {6'h0, en, 1'b1});
      chk("irq pin", {31'h0, en}, {31'h0, irq});
   endtask : run_conv

   task tally_and_finish();
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : tally_and_finish

   initial begin
      #100000;
      err_total++;
      tally_and_finish();
   end

   // ****************************************
   // test sequence
   // ****************************************
   initial begin
      err_total = 0;
      n_checks = 0;
      smp = 0;
      rst_n = 1'b0;
      hsel = 1'b0;
      hwrite = 1'b0;
      htrans = 2'h0;
      haddr = 32'h0;
      hsize = 3'h2;
      hwdata = 32'h0;
      pin = 1'b1;
      for (int i = 0; i < 8; i++) lvl[i] = 8'h17 + 8'h21 * i[7:0];
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      rd_chk("mode reset", 32'h0, MODE_RESET);
      rd_chk("go reset", 32'h8, 8'h7F);
      rd_chk("unmapped", 32'h10, 8'h00);
      bus(1'b1, 32'h0, 32'h0);
      rd_chk("mode reserved", 32'h0, 8'h30);
      bus(1'b1, 32'h8, 32'h7F);
      rd_chk("go reserved", 32'h8, 8'h7F);
      // the model settles at once, so short periods are safe here
      run_conv(8'h05, 1'b1, lvl[1], 54);
      repeat (20) @(posedge clk);
      rd_chk("result held", 32'h4, lvl[1]);
      run_conv(8'h8B, 1'b0, lvl[7], 23);
      run_conv(8'h02, 1'b1, 8'h00, 54);
      // reserved channel codes convert with no input selected
      run_conv(8'h8C, 1'b0, 8'h00, 23);
      res = {24'h0, lvl[7] ^ 8'h5A};
      lvl[1] <= res[7:0];
      run_conv(8'h05, 1'b1, res[7:0], 54);
      // abort mid-run: no request must follow
      bus(1'b1, 32'hC, 32'h3);
      bus(1'b1, 32'h8, 32'h80);
      repeat (10) @(posedge clk);
      bus(1'b1, 32'h8, 32'h00);
      rd_chk("go aborted", 32'h8, 8'h7F);
      repeat (80) @(posedge clk);
      rd_chk("no request", 32'hC, 8'h02);
      chk("irq idle", 32'h0, {31'h0, irq});
      rst_n <= 1'b0;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      rd_chk("result kept", 32'h4, res[7:0]);
      rd_chk("mode again", 32'h0, 8'h30);
      // trigger pin while disabled
      bus(1'b1, 32'h0, 32'h05);
      pin <= 1'b0;
      repeat (6) @(posedge clk);
      pin <= 1'b1;
      repeat (6) @(posedge clk);
      rd_chk("trigger off", 32'h8, 8'h7F);
      // rising polarity: a falling edge is ignored
      bus(1'b1, 32'hC, 32'h7);
      bus(1'b1, 32'h0, 32'h45);
      pin <= 1'b0;
      repeat (6) @(posedge clk);
      rd_chk("wrong edge", 32'h8, 8'h7F);
      pin <= 1'b1;
      repeat (6) @(posedge clk);
      rd_chk("rise start", 32'h8, 8'hFF);
      wait_done();
      rd_chk("trig result", 32'h4, res[7:0]);
      bus(1'b1, 32'hC, 32'h3);
      pin <= 1'b0;
      repeat (6) @(posedge clk);
      rd_chk("fall start", 32'h8, 8'hFF);
      wait_done();
      rd_chk("fall irq", 32'hC, 8'h03);
      tally_and_finish();
   end
endmodule : sac_adc_control_tb
